// ===== hdl/bprc_reg_bank.sv
// Register bank holding the three fast-bus peripheral reset registers.
`timescale 1ns/1ps
`default_nettype none
module bprc_reg_bank
	import bprc_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Access from the bus slave.
	bprc_reg_if.bank         rif,
	// Register contents.
	output logic      [31:0] fast_bus1_q,
	output logic      [31:0] fast_bus2_q,
	output logic      [31:0] fast_bus3_q
);
	// Select decode of the write target.
	wire wr1 = rif.wr_en && (rif.wr_sel == 2'h0);
	wire wr2 = rif.wr_en && (rif.wr_sel == 2'h1);
	wire wr3 = rif.wr_en && (rif.wr_sel == 2'h2);

	bprc_reg_word #(.MASK(FAST_BUS1_MASK), .RESET(FAST_BUS1_RESET)) u_bus1
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (wr1),
		.wr_data (rif.wr_data),
		.wr_strb (rif.wr_strb),
		.q       (fast_bus1_q)
	);
	bprc_reg_word #(.MASK(FAST_BUS2_MASK), .RESET(FAST_BUS2_RESET)) u_bus2
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (wr2),
		.wr_data (rif.wr_data),
		.wr_strb (rif.wr_strb),
		.q       (fast_bus2_q)
	);
	bprc_reg_word #(.MASK(FAST_BUS3_MASK), .RESET(FAST_BUS3_RESET)) u_bus3
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (wr3),
		.wr_data (rif.wr_data),
		.wr_strb (rif.wr_strb),
		.q       (fast_bus3_q)
	);

	// Read multiplexer; unused select reads zero.
	assign rif.rd_data = (rif.rd_sel == 2'h0) ? fast_bus1_q :
	                     (rif.rd_sel == 2'h1) ? fast_bus2_q :
	                     (rif.rd_sel == 2'h2) ? fast_bus3_q : 32'h00000000;
endmodule
`default_nettype wire

// ===== hdl/bprc_reg_word.sv
// One reset register word with byte-lane writes and a fixed writable mask.
`timescale 1ns/1ps
`default_nettype none
module bprc_reg_word
#(
	parameter logic [31:0] MASK  = 32'h00000000,
	parameter logic [31:0] RESET = 32'h00000000
)
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Write port.
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	input  wire logic [3:0]  wr_strb,
	// Stored value.
	output logic      [31:0] q
);
	logic [31:0] q_r;
	logic [31:0] q_nxt;

	// Each lane takes new data only where its strobe is set.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_lane
			assign q_nxt[8*g +: 8] = (wr_en && wr_strb[g]) ?
				(wr_data[8*g +: 8] & MASK[8*g +: 8]) : q_r[8*g +: 8];
		end
	endgenerate

	// Register holds its bits until software writes them.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q_r <= RESET;
		else
			q_r <= q_nxt;
	end

	assign q = q_r;
endmodule
`default_nettype wire

// ===== hdl/bprc_top.sv
// AXI4-Lite peripheral reset control for the three fast-bus domains.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bprc_top
	import bprc_pkg::*;
(
	// Clock and reset.
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// AXI4-Lite write address.
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	// AXI4-Lite write data.
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	// AXI4-Lite write response.
	output logic      [1:0]  BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// AXI4-Lite read address.
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	// AXI4-Lite read data.
	output logic      [31:0] RDATA,
	output logic      [1:0]  RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// Reset requests, first fast bus.
	output logic             LOW_ENERGY_RADIO_RESET,
	output logic             DMA_CONTROLLER_RESET_BIT,
	output logic             WIRELESS_LAN_RESET,
	output logic             CHECKSUM_UNIT_RESET,
	output logic             GPIO_C_RESET,
	output logic             GPIO_B_RESET,
	output logic             GPIO_A_RESET,
	// Reset requests, second fast bus.
	output logic             RANDOM_GENERATOR_RESET,
	output logic             HASH_UNIT_RESET,
	output logic             CIPHER_UNIT_RESET,
	output logic             PUBLIC_KEY_UNIT_RESET,
	// Reset request, third fast bus.
	output logic             QUAD_SERIAL_FLASH_RESET
);
	// ************************************************************
	// Write channel
	// ************************************************************
	bprc_reg_if rif ();

	logic        aw_held_r;
	logic [7:0]  aw_addr_r;
	logic        w_held_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;

	// Address and data are caught independently, so either may come first.
	wire aw_take  = AWVALID && !aw_held_r && !bvalid_r;
	wire w_take   = WVALID && !w_held_r && !bvalid_r;
	wire wr_fire  = aw_held_r && w_held_r && !bvalid_r;
	wire [7:0] wa = aw_addr_r;
	wire wa_hit1  = (wa == FAST_BUS1_OFFSET);
	wire wa_hit2  = (wa == FAST_BUS2_OFFSET);
	wire wa_hit3  = (wa == FAST_BUS3_OFFSET);
	wire wa_hit   = wa_hit1 || wa_hit2 || wa_hit3;

	assign rif.wr_en   = wr_fire && wa_hit;
	assign rif.wr_sel  = wa_hit1 ? 2'h0 : (wa_hit2 ? 2'h1 : 2'h2);
	assign rif.wr_data = w_data_r;
	assign rif.wr_strb = w_strb_r;

	// Address holding register.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end
		else if (aw_take)
		begin
			aw_held_r <= 1'b1;
			aw_addr_r <= {AWADDR[7:2], 2'h0};
		end
		else if (wr_fire)
			aw_held_r <= 1'b0;
	end

	// Data holding register.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end
		else if (w_take)
		begin
			w_held_r <= 1'b1;
			w_data_r <= WDATA;
			w_strb_r <= WSTRB;
		end
		else if (wr_fire)
			w_held_r <= 1'b0;
	end

	// Response: unmapped addresses get SLVERR and change nothing.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r  <= wa_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (BREADY)
			bvalid_r <= 1'b0;
	end

	// Ready pulses one cycle on the edge that takes each channel.
	logic awready_r;
	logic wready_r;
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
		end
		else
		begin
			awready_r <= AWVALID && !awready_r && !aw_held_r && !bvalid_r;
			wready_r  <= WVALID && !wready_r && !w_held_r && !bvalid_r;
		end
	end

	// ************************************************************
	// Read channel
	// ************************************************************
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	wire [7:0] ra  = {ARADDR[7:2], 2'h0};
	wire ra_hit1   = (ra == FAST_BUS1_OFFSET);
	wire ra_hit2   = (ra == FAST_BUS2_OFFSET);
	wire ra_hit3   = (ra == FAST_BUS3_OFFSET);
	wire ra_hit    = ra_hit1 || ra_hit2 || ra_hit3;
	wire ar_fire   = ARVALID && arready_r;

	assign rif.rd_sel = ra_hit1 ? 2'h0 : (ra_hit2 ? 2'h1 : (ra_hit3 ? 2'h2 : 2'h3));

	// Read is taken when ARREADY and ARVALID meet; data follows next cycle.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= RESP_OKAY;
		end
		else
		begin
			arready_r <= ARVALID && !arready_r && !rvalid_r;
			if (ar_fire)
			begin
				rvalid_r <= 1'b1;
				rdata_r  <= rif.rd_data;
				rresp_r  <= ra_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (RREADY)
				rvalid_r <= 1'b0;
		end
	end

	// ************************************************************
	// Register bank and reset requests
	// ************************************************************
	logic [31:0] bus1_q;
	logic [31:0] bus2_q;
	logic [31:0] bus3_q;

	bprc_reg_bank u_bank
	(
		.clk         (CLK),
		.rst_n       (RSTN),
		.rif         (rif),
		.fast_bus1_q (bus1_q),
		.fast_bus2_q (bus2_q),
		.fast_bus3_q (bus3_q)
	);

	logic [11:0] req_r;
	logic [11:0] req_nxt;

	assign req_nxt[0]  = bus1_q[LOW_ENERGY_RADIO_RESET_POS];
	assign req_nxt[1]  = bus1_q[DMA_CONTROLLER_RESET_BIT_POS];
	assign req_nxt[2]  = bus1_q[WIRELESS_LAN_RESET_POS];
	assign req_nxt[3]  = bus1_q[CHECKSUM_UNIT_RESET_POS];
	assign req_nxt[4]  = bus1_q[GPIO_C_RESET_POS];
	assign req_nxt[5]  = bus1_q[GPIO_B_RESET_POS];
	assign req_nxt[6]  = bus1_q[GPIO_A_RESET_POS];
	assign req_nxt[7]  = bus2_q[RANDOM_GENERATOR_RESET_POS];
	assign req_nxt[8]  = bus2_q[HASH_UNIT_RESET_POS];
	assign req_nxt[9]  = bus2_q[CIPHER_UNIT_RESET_POS];
	assign req_nxt[10] = bus2_q[PUBLIC_KEY_UNIT_RESET_POS];
	assign req_nxt[11] = bus3_q[QUAD_SERIAL_FLASH_RESET_POS];

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			req_r <= 12'h000;
		else
			req_r <= req_nxt;
	end

	// Outputs straight from flip-flops.
	assign AWREADY = awready_r;
	assign WREADY  = wready_r;
	assign BVALID  = bvalid_r;
	assign BRESP   = bresp_r;
	assign ARREADY = arready_r;
	assign RVALID  = rvalid_r;
	assign RDATA   = rdata_r;
	assign RRESP   = rresp_r;

	assign LOW_ENERGY_RADIO_RESET   = req_r[0];
	assign DMA_CONTROLLER_RESET_BIT = req_r[1];
	assign WIRELESS_LAN_RESET       = req_r[2];
	assign CHECKSUM_UNIT_RESET      = req_r[3];
	assign GPIO_C_RESET             = req_r[4];
	assign GPIO_B_RESET             = req_r[5];
	assign GPIO_A_RESET             = req_r[6];
	assign RANDOM_GENERATOR_RESET   = req_r[7];
	assign HASH_UNIT_RESET          = req_r[8];
	assign CIPHER_UNIT_RESET        = req_r[9];
	assign PUBLIC_KEY_UNIT_RESET    = req_r[10];
	assign QUAD_SERIAL_FLASH_RESET  = req_r[11];

	// ************************************************************
	// Assertions
	// ************************************************************
	a_req_follows_bit: assert property (@(posedge CLK) disable iff (!RSTN)
		req_r == $past(req_nxt)) else $error("Reset request did not follow bit.");

	a_reg2_reserved: assert property (@(posedge CLK) disable iff (!RSTN)
		(bus2_q & ~FAST_BUS2_MASK) == 32'h00000000) else $error("Reserved bit set.");

	a_reg3_reserved: assert property (@(posedge CLK) disable iff (!RSTN)
		(bus3_q & ~FAST_BUS3_MASK) == 32'h00000000) else $error("Reserved bit set.");

	a_reg1_reserved: assert property (@(posedge CLK) disable iff (!RSTN)
		(bus1_q & ~FAST_BUS1_MASK) == 32'h00000000) else $error("Reserved bit set.");

	a_hold_no_write: assert property (@(posedge CLK) disable iff (!RSTN)
		!rif.wr_en |=> $stable(bus1_q) && $stable(bus2_q) && $stable(bus3_q))
		else $error("Register changed without write.");

	a_lane_kept: assert property (@(posedge CLK) disable iff (!RSTN)
		rif.wr_en && !rif.wr_strb[0] |=> bus1_q[7:0] == $past(bus1_q[7:0]))
		else $error("Unstrobed lane changed.");

	a_write_bus1: assert property (@(posedge CLK) disable iff (!RSTN)
		rif.wr_en && wa_hit1 && rif.wr_strb == 4'hF
		|=> bus1_q == ($past(w_data_r) & FAST_BUS1_MASK) ##1 GPIO_A_RESET == bus1_q[0])
		else $error("Write to first register lost.");

	a_zero_out_reset: assert property (@(posedge CLK)
		$rose(RSTN) |-> req_r == 12'h000 && bus1_q == 32'h0 && bus2_q == 32'h0 && bus3_q == 32'h0)
		else $error("Not zero after reset.");

	a_bresp_after: assert property (@(posedge CLK) disable iff (!RSTN)
		wr_fire |=> BVALID && (BRESP == RESP_OKAY) == $past(wa_hit))
		else $error("Write response wrong.");

	a_read_answer: assert property (@(posedge CLK) disable iff (!RSTN)
		ar_fire |=> RVALID && (RRESP == RESP_OKAY) == $past(ra_hit))
		else $error("Read response wrong.");

	a_bus2_request: assert property (@(posedge CLK) disable iff (!RSTN)
		rif.wr_en && wa_hit2 && rif.wr_strb[0]
		|=> ##1 HASH_UNIT_RESET == $past(w_data_r[HASH_UNIT_RESET_POS], 2))
		else $error("Hash unit request did not follow write.");

	a_bus3_request: assert property (@(posedge CLK) disable iff (!RSTN)
		rif.wr_en && wa_hit3 && rif.wr_strb[0]
		|=> ##1 QUAD_SERIAL_FLASH_RESET == $past(w_data_r[QUAD_SERIAL_FLASH_RESET_POS], 2))
		else $error("Flash request did not follow write.");
endmodule
`default_nettype wire

// ===== include/bprc_pkg.sv
// Package of offsets, field positions and reset values for the peripheral reset control.
package bprc_pkg;

	// Register byte offsets.
	localparam logic [7:0]  FAST_BUS1_OFFSET = 8'h10;
	localparam logic [7:0]  FAST_BUS2_OFFSET = 8'h14;
	localparam logic [7:0]  FAST_BUS3_OFFSET = 8'h18;

	// Reset values of all three registers.
	localparam logic [31:0] FAST_BUS1_RESET  = 32'h00000000;
	localparam logic [31:0] FAST_BUS2_RESET  = 32'h00000000;
	localparam logic [31:0] FAST_BUS3_RESET  = 32'h00000000;

	// Field positions, first register.
	localparam int LOW_ENERGY_RADIO_RESET_POS   = 31;
	localparam int DMA_CONTROLLER_RESET_BIT_POS = 21;
	localparam int WIRELESS_LAN_RESET_POS       = 13;
	localparam int CHECKSUM_UNIT_RESET_POS      = 12;
	localparam int GPIO_C_RESET_POS             = 2;
	localparam int GPIO_B_RESET_POS             = 1;
	localparam int GPIO_A_RESET_POS             = 0;

	// Field positions, second register.
	localparam int RANDOM_GENERATOR_RESET_POS   = 6;
	localparam int HASH_UNIT_RESET_POS          = 5;
	localparam int CIPHER_UNIT_RESET_POS        = 4;
	localparam int PUBLIC_KEY_UNIT_RESET_POS    = 3;

	// Field positions, third register.
	localparam int QUAD_SERIAL_FLASH_RESET_POS  = 1;

	// Writable-bit masks; every other bit is reserved and reads zero.
	localparam logic [31:0] FAST_BUS1_MASK = 32'h80203007;
	localparam logic [31:0] FAST_BUS2_MASK = 32'h00000078;
	localparam logic [31:0] FAST_BUS3_MASK = 32'h00000002;

	// AXI response codes.
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ===== include/bprc_reg_if.sv
// Interface carrying register writes and read data between the slave and the register bank.
`timescale 1ns/1ps
`default_nettype none
interface bprc_reg_if;
	logic        wr_en;
	logic [1:0]  wr_sel;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [1:0]  rd_sel;
	logic [31:0] rd_data;

	modport slave
	(
		output wr_en,
		output wr_sel,
		output wr_data,
		output wr_strb,
		output rd_sel,
		input  rd_data
	);
	modport bank
	(
		input  wr_en,
		input  wr_sel,
		input  wr_data,
		input  wr_strb,
		input  rd_sel,
		output rd_data
	);
endinterface
`default_nettype wire

// ===== sim/bprc_top_tb.sv
// Self-checking bench for the fast-bus peripheral reset control.
`timescale 1ns/1ps
`default_nettype none
module bprc_top_tb;
	import bprc_pkg::*;
	// ********************************
	// Stimulus and observed signals
	// ********************************
	logic        CLK;
	logic        RSTN;
	logic [7:0]  AWADDR;
	logic [7:0]  ARADDR;
	logic [31:0] WDATA;
	logic [3:0]  WSTRB;
	logic        AWVALID;
	logic        WVALID;
	logic        BREADY;
	logic        ARVALID;
	logic        RREADY;
	logic        AWREADY;
	logic        WREADY;
	logic        BVALID;
	logic        ARREADY;
	logic        RVALID;
	logic [1:0]  BRESP;
	logic [1:0]  RRESP;
	logic [31:0] RDATA;
	logic [11:0] rq;
	logic [31:0] out1;
	logic [31:0] out2;
	logic [31:0] out3;
	int          fails = 0;
	int          checked = 0;

	// Request lines packed back into register layout, built from the bit map by hand.
	assign out1 = {rq[11], 9'h000, rq[10], 7'h00, rq[9], rq[8], 9'h000, rq[7:5]};
	assign out2 = {25'h0000000, rq[4:1], 3'h0};
	assign out3 = {30'h00000000, rq[0], 1'h0};

	always #5 CLK = ~CLK;

	bprc_top i_bprc_top
	(
		.CLK(CLK), .RSTN(RSTN),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.LOW_ENERGY_RADIO_RESET(rq[11]), .DMA_CONTROLLER_RESET_BIT(rq[10]),
		.WIRELESS_LAN_RESET(rq[9]), .CHECKSUM_UNIT_RESET(rq[8]),
		.GPIO_C_RESET(rq[7]), .GPIO_B_RESET(rq[6]), .GPIO_A_RESET(rq[5]),
		.RANDOM_GENERATOR_RESET(rq[4]), .HASH_UNIT_RESET(rq[3]),
		.CIPHER_UNIT_RESET(rq[2]), .PUBLIC_KEY_UNIT_RESET(rq[1]),
		.QUAD_SERIAL_FLASH_RESET(rq[0])
	);

	// ********************************
	// Shared tasks
	// ********************************
	task automatic wrap_up();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A hung handshake counts as a mismatch and ends the run.
	task automatic bound(input logic seen);
		if (seen !== 1'b1)
		begin
			fails++;
			wrap_up();
		end
	endtask

	// Address and data are offered together and each is dropped once taken.
	// Slave outputs are copied mid-cycle, where they already hold what the next rising
	// edge samples; reading them right after the edge would race the design's update.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		logic aw_s;
		logic w_s;
		logic b_s;
		logic [1:0] r_s;
		n = 0;
		b_s = 1'b0;
		r_s = 2'h0;
		@(posedge CLK);
		AWADDR <= a;
		AWVALID <= 1'b1;
		WDATA <= d;
		WSTRB <= s;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do
		begin
			@(negedge CLK);
			aw_s = AWREADY;
			w_s = WREADY;
			b_s = BVALID;
			r_s = BRESP;
			@(posedge CLK);
			n++;
			if (aw_s) AWVALID <= 1'b0;
			if (w_s) WVALID <= 1'b0;
		end
		while (b_s !== 1'b1 && n < 200);
		bound(b_s);
		BREADY <= 1'b0;
		chk({30'h0, r_s}, {30'h0, er});
		@(negedge CLK);
	endtask

	// Ends mid-cycle, so callers compare settled outputs and the next task starts on an edge.
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic ar_s;
		logic rv_s;
		logic [31:0] rd_s;
		logic [1:0] rr_s;
		n = 0;
		rv_s = 1'b0;
		rd_s = 32'h00000000;
		rr_s = 2'h0;
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do
		begin
			@(negedge CLK);
			ar_s = ARREADY;
			rv_s = RVALID;
			rd_s = RDATA;
			rr_s = RRESP;
			@(posedge CLK);
			n++;
			if (ar_s) ARVALID <= 1'b0;
		end
		while (rv_s !== 1'b1 && n < 200);
		bound(rv_s);
		RREADY <= 1'b0;
		chk(rd_s, ed);
		chk({30'h0, rr_s}, {30'h0, er});
		@(negedge CLK);
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset();
		chk(out1 | out2 | out3, 32'h00000000);
		axi_rd(8'h10, 32'h00000000, 2'h0);
		axi_rd(8'h14, 32'h00000000, 2'h0);
		axi_rd(8'h18, 32'h00000000, 2'h0);
	endtask

	// Each field alone, so a swapped or shifted bit shows on the wrong request line.
	task automatic t_fields();
		logic [31:0] m;
		logic [31:0] v;
		for (int r = 0; r < 3; r++)
		begin
			m = (r == 0) ? 32'h80203007 : ((r == 1) ? 32'h00000078 : 32'h00000002);
			for (int b = 0; b < 32; b++)
			begin
				v = 32'h00000001 << b;
				// stimulus sets writable bits only; reserved ones stay zero.
				if (m[b])
				begin
					axi_wr(8'h10 + 8'(4 * r), v, 4'hF, 2'h0);
					axi_rd(8'h10 + 8'(4 * r), v, 2'h0);
					chk((r == 0) ? out1 : ((r == 1) ? out2 : out3), v);
					chk(out1 | out2 | out3, v);
					axi_wr(8'h10 + 8'(4 * r), 32'h00000000, 4'hF, 2'h0);
					chk(out1 | out2 | out3, 32'h00000000);
				end
			end
		end
	endtask

	task automatic t_lanes();
		axi_wr(8'h10, 32'h80203007, 4'hF, 2'h0);
		axi_wr(8'h10, 32'h00000000, 4'h1, 2'h0);
		axi_rd(8'h10, 32'h80203000, 2'h0);
		axi_wr(8'h10, 32'h00000000, 4'h2, 2'h0);
		axi_rd(8'h10, 32'h80200000, 2'h0);
		axi_wr(8'h10, 32'h00000000, 4'hC, 2'h0);
		axi_rd(8'h10, 32'h00000000, 2'h0);
		chk(out1, 32'h00000000);
		axi_wr(8'h14, 32'h00000078, 4'hE, 2'h0);
		axi_rd(8'h14, 32'h00000000, 2'h0);
		axi_wr(8'h14, 32'h00000078, 4'h1, 2'h0);
		axi_wr(8'h18, 32'h00000002, 4'h1, 2'h0);
		axi_rd(8'h14, 32'h00000078, 2'h0);
		axi_rd(8'h18, 32'h00000002, 2'h0);
		chk(out2, 32'h00000078);
		chk(out3, 32'h00000002);
	endtask

	// Unmapped places answer with an error and leave the first and third registers alone.
	task automatic t_unmapped();
		axi_wr(8'h1C, 32'h00000000, 4'hF, 2'h2);
		axi_wr(8'h0C, 32'h80203007, 4'hF, 2'h2);
		axi_rd(8'h1C, 32'h00000000, 2'h2);
		axi_rd(8'h0C, 32'h00000000, 2'h2);
		axi_rd(8'h18, 32'h00000002, 2'h0);
		axi_rd(8'h10, 32'h00000000, 2'h0);
		chk(out3, 32'h00000002);
		chk(out1, 32'h00000000);
	endtask

	// A second reset in mid-run must drop every request, not only at power-up.
	task automatic t_mid_reset();
		axi_wr(8'h10, 32'h80203007, 4'hF, 2'h0);
		chk(out1, 32'h80203007);
		@(posedge CLK);
		RSTN <= 1'b0;
		repeat (3) @(posedge CLK);
		chk(out1 | out2 | out3, 32'h00000000);
		RSTN <= 1'b1;
		@(posedge CLK);
		t_reset();
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		CLK = 1'b0;
		RSTN = 1'b0;
		AWADDR = 8'h00;
		ARADDR = 8'h00;
		WDATA = 32'h00000000;
		WSTRB = 4'h0;
		AWVALID = 1'b0;
		WVALID = 1'b0;
		BREADY = 1'b0;
		ARVALID = 1'b0;
		RREADY = 1'b0;
		repeat (16) @(posedge CLK);
		RSTN <= 1'b1;
		@(posedge CLK);
		t_reset();
		t_fields();
		t_lanes();
		t_unmapped();
		t_mid_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
